// ==== verilog/ebtsp_pkg.sv ====
// Constants, register map and ratio decoding for the 8-bit timer with shared prescaler.
// Assumes register indices are word indices; byte address is four times the index.
package ebtsp_pkg;

    // Register indices and bus width.
    localparam int             ADDR_W        = 10;
    localparam logic [7:0]     IDX_COUNT     = 8'h01;
    localparam logic [7:0]     IDX_INTERRUPT_CONTROL    = 8'h0B;
    localparam logic [7:0]     IDX_INTERRUPT_CONTROL_HI = 8'h8B;
    localparam logic [7:0]     IDX_OPTION    = 8'h81;

    // Option register fields.
    localparam int             OPT_SRC_BIT    = 5;
    localparam int             OPT_EDGE_BIT   = 4;
    localparam int             OPT_ASSIGN_BIT = 3;
    localparam int             OPT_RATIO_LSB  = 0;
    localparam int             RATIO_W        = 3;

    // Interrupt control fields.
    localparam int             INT_GIE_BIT   = 7;
    localparam int             INT_OVIE_BIT  = 5;
    localparam int             INT_OVF_BIT   = 2;
    localparam logic [7:0]     INT_IMPL_MASK = 8'hA4;

    // Reset values and counts.
    localparam logic [7:0]     OPTION_RESET  = 8'hFF;
    localparam logic [7:0]     INTERRUPT_CONTROL_RESET  = 8'h00;
    localparam logic [7:0]     COUNT_RESET   = 8'h00;
    localparam logic [7:0]     COUNT_MAX     = 8'hFF;
    localparam logic [1:0]     INHIBIT_CYCLES = 2'h2;

    // Mask of low prescaler bits that must all be ones for an output tick.
    // Timer side divides by 2^(n+1), watchdog side by 2^n.
    function automatic logic [7:0] ratio_mask(input logic [RATIO_W-1:0] n,
                                              input logic               to_timer);
        logic [8:0] one_hot;
        one_hot = 9'h001 << n;
        if (to_timer) begin
            one_hot = {one_hot[7:0], 1'b0};
        end
        return 8'(one_hot - 9'h001);
    endfunction

endpackage

// ==== verilog/ebtsp_presc_if.sv ====
// Interface between the timer control logic and the shared prescaler.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface ebtsp_presc_if;
    logic       src_tick;
    logic       clear;
    logic       to_timer;
    logic [2:0] ratio;
    logic       out_tick;
    logic [7:0] count;

    modport ctrl  (output src_tick, output clear, output to_timer, output ratio,
                   input out_tick, input count);
    modport presc (input src_tick, input clear, input to_timer, input ratio,
                   output out_tick, output count);
endinterface

// ==== verilog/ebtsp_pin_sync.sv ====
// Three-stage synchroniser with agreement filter and edge pulses for the count pin.
// Assumes the pin is asynchronous to clk_sys.
`timescale 1ns/100ps
module ebtsp_pin_sync (
    // Clock and reset.
    input  wire logic clk_sys,
    input  wire logic resetn,
    // Pin side.
    input  wire logic pin,
    // Synchronised side.
    output logic      level,
    output logic      rise,
    output logic      fall
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic stable;
    } ebtsp_sync_s;

    ebtsp_sync_s st;
    ebtsp_sync_s next_st;
    logic        agree;

    // A change is accepted only once the second and third stages agree.
    always_comb begin
        next_st        = st;
        next_st.s1     = pin;
        next_st.s2     = st.s1;
        next_st.s3     = st.s2;
        agree          = (st.s2 == st.s3);
        if (agree) begin
            next_st.stable = st.s3;
        end
        rise  = agree && st.s3 && !st.stable;
        fall  = agree && !st.s3 && st.stable;
        level = st.stable;
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

// ==== verilog/ebtsp_prescaler.sv ====
// Shared 8-bit prescaler; divides its source tick by the selected power of two.
// Assumes the control side selects source and clear according to the assignment.
`timescale 1ns/100ps
module ebtsp_prescaler (
    // Clock and reset.
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    // Control side.
    ebtsp_presc_if.presc    pif
);
    typedef struct packed {
        logic [7:0] count;
    } ebtsp_presc_s;

    ebtsp_presc_s st;
    ebtsp_presc_s next_st;
    logic [7:0]   mask;

    always_comb begin
        next_st      = st;
        mask         = ebtsp_pkg::ratio_mask(pif.ratio, pif.to_timer);
        pif.out_tick = pif.src_tick && ((st.count & mask) == mask);
        if (pif.clear) begin
            next_st.count = 8'h00;
        end else if (pif.src_tick) begin
            next_st.count = st.count + 8'h01;
        end
        pif.count = st.count;
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    logic [2:0] ratio_d;
    logic       assign_d;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ratio_d  <= 3'h0;
            assign_d <= 1'b0;
        end else begin
            ratio_d  <= pif.ratio;
            assign_d <= pif.to_timer;
        end
    end

    // Helper that counts source ticks since the last output or clear.
    // A ratio or assignment change zeroes the count and drops gap_ok, so checking rests until the next output or clear.
    logic [8:0] gap;
    logic       gap_ok;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            gap    <= 9'h000;
            gap_ok <= 1'b0;
        end else if (pif.ratio != ratio_d || pif.to_timer != assign_d) begin
            gap    <= 9'h000;
            gap_ok <= 1'b0;
        end else if (pif.clear || pif.out_tick) begin
            gap    <= 9'h000;
            gap_ok <= 1'b1;
        end else if (pif.src_tick) begin
            gap    <= gap + 9'h001;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    ratio_spacing_a: assert property (
        (pif.out_tick && gap_ok && pif.ratio == ratio_d && pif.to_timer == assign_d
         && $stable(pif.ratio) && $stable(pif.to_timer))
        |-> ({1'b0, ebtsp_pkg::ratio_mask(pif.ratio, pif.to_timer)} == gap))
        else $error("prescaler output spacing does not match ratio");

    clear_zero_a: assert property (pif.clear |=> pif.count == 8'h00)
        else $error("prescaler not cleared");

    div256_cover: cover property (pif.out_tick && pif.to_timer && pif.ratio == 3'h7);
endmodule

// ==== verilog/ebtsp_timer.sv ====
// Top of the 8-bit timer/counter with a prescaler shared with the watchdog.
// Assumes one clk_sys cycle per instruction cycle and a single-cycle strobe register port.
`timescale 1ns/100ps

// Functional notes
// - Eight-bit counter sets overflow flag when wrapping from FFh to 00h.
// - Source select zero counts every instruction cycle when undivided.
// - Any counter write blocks counting for the next two cycles.
// - Source select one counts edges of the external count pin.
// - Edge select zero counts rising edges, one counts falling edges.
// - Pin edges are synchronised before counting; source must meet input timing.
// - One 8-bit prescaler serves timer or watchdog; the other runs undivided.
// - Software can neither read nor write the prescaler count.
// - Assignment bit clear routes prescaler to counter, ratios 1:2 to 1:256.
// - Assignment bit set routes prescaler to watchdog, ratios 1:1 to 1:128.
// - Counter writes clear the prescaler when it serves the counter.
// - Watchdog clear instruction clears prescaler when it serves the watchdog.
module ebtsp_timer (
    // Clock and reset.
    input  wire logic                           clk_sys,
    input  wire logic                           resetn,
    // Register port.
    input  wire logic [ebtsp_pkg::ADDR_W-1:0]   addr,
    input  wire logic [7:0]                     wdata,
    input  wire logic                           wr_en,
    input  wire logic                           rd_en,
    output logic      [7:0]                     rdata,
    // External count pin.
    input  wire logic                           external_count_input,
    // Watchdog side.
    input  wire logic                           watchdog_clear_instr,
    input  wire logic                           watchdog_tick_in,
    output logic                                watchdog_tick_out,
    // Interrupt.
    output logic                                irq
);
    typedef struct packed {
        logic [7:0] count_value;
        logic [7:0] option_config;
        logic [7:0] interrupt_control;
        logic [1:0] inhibit;
        logic [7:0] rdata;
    } ebtsp_state_s;

    ebtsp_state_s st;
    ebtsp_state_s next_st;

    ebtsp_presc_if pif ();

    logic pin_level;
    logic pin_rise;
    logic pin_fall;

    ebtsp_pin_sync u_sync (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .pin     (external_count_input),
        .level   (pin_level),
        .rise    (pin_rise),
        .fall    (pin_fall)
    );

    ebtsp_prescaler u_presc (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .pif     (pif.presc)
    );

    // Word-aligned decode of a register index.
    function automatic logic addr_hit(input logic [ebtsp_pkg::ADDR_W-1:0] a,
                                      input logic [7:0]                   idx);
        return (a[1:0] == 2'h0) && (a[ebtsp_pkg::ADDR_W-1:2] == idx);
    endfunction

    logic       wr_count;
    logic       wr_interrupt_control;
    logic       wr_option;
    logic       rd_interrupt_control;
    logic       src_counter;
    logic       edge_falling;
    logic       to_timer;
    logic       src_tick;
    logic       count_tick;
    logic       inc;
    logic       overflow;

    always_comb begin
        next_st      = st;
        wr_count     = wr_en && addr_hit(addr, ebtsp_pkg::IDX_COUNT);
        wr_interrupt_control    = wr_en && (addr_hit(addr, ebtsp_pkg::IDX_INTERRUPT_CONTROL)
                                 || addr_hit(addr, ebtsp_pkg::IDX_INTERRUPT_CONTROL_HI));
        wr_option    = wr_en && addr_hit(addr, ebtsp_pkg::IDX_OPTION);
        rd_interrupt_control    = rd_en && (addr_hit(addr, ebtsp_pkg::IDX_INTERRUPT_CONTROL)
                                 || addr_hit(addr, ebtsp_pkg::IDX_INTERRUPT_CONTROL_HI));
        src_counter  = st.option_config[ebtsp_pkg::OPT_SRC_BIT];
        edge_falling = st.option_config[ebtsp_pkg::OPT_EDGE_BIT];
        to_timer     = !st.option_config[ebtsp_pkg::OPT_ASSIGN_BIT];

        // Count source: every cycle in timer mode, selected pin edge in counter mode.
        if (!src_counter) begin
            src_tick = 1'b1;
        end else begin
            src_tick = edge_falling ? pin_fall : pin_rise;
        end

        // The prescaler serves exactly one unit; the other bypasses it.
        pif.to_timer      = to_timer;
        pif.ratio         = st.option_config[ebtsp_pkg::OPT_RATIO_LSB +: ebtsp_pkg::RATIO_W];
        pif.src_tick      = to_timer ? src_tick : watchdog_tick_in;
        pif.clear         = to_timer ? wr_count : watchdog_clear_instr;
        count_tick        = to_timer ? pif.out_tick : src_tick;
        watchdog_tick_out = to_timer ? watchdog_tick_in : pif.out_tick;

        inc      = count_tick && (st.inhibit == 2'h0);
        overflow = inc && !wr_count && (st.count_value == ebtsp_pkg::COUNT_MAX);

        // Counter and inhibit window.
        if (wr_count) begin
            next_st.count_value = wdata;
            next_st.inhibit     = ebtsp_pkg::INHIBIT_CYCLES;
        end else begin
            if (inc) begin
                next_st.count_value = st.count_value + 8'h01;
            end
            if (st.inhibit != 2'h0) begin
                next_st.inhibit = st.inhibit - 2'h1;
            end
        end

        // Configuration.
        if (wr_option) begin
            next_st.option_config = wdata;
        end

        // Interrupt control: read clears the flag, a new overflow wins over any clear.
        if (wr_interrupt_control) begin
            next_st.interrupt_control = wdata & ebtsp_pkg::INT_IMPL_MASK;
        end
        if (rd_interrupt_control) begin
            next_st.interrupt_control[ebtsp_pkg::INT_OVF_BIT] = 1'b0;
        end
        if (overflow) begin
            next_st.interrupt_control[ebtsp_pkg::INT_OVF_BIT] = 1'b1;
        end

        // Read data stand for one cycle only; the prescaler has no address.
        next_st.rdata = 8'h00;
        if (rd_en) begin
            if (addr_hit(addr, ebtsp_pkg::IDX_COUNT)) begin
                next_st.rdata = st.count_value;
            end else if (rd_interrupt_control) begin
                next_st.rdata = st.interrupt_control;
            end else if (addr_hit(addr, ebtsp_pkg::IDX_OPTION)) begin
                next_st.rdata = st.option_config;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st.count_value       <= ebtsp_pkg::COUNT_RESET;
            st.option_config     <= ebtsp_pkg::OPTION_RESET;
            st.interrupt_control <= ebtsp_pkg::INTERRUPT_CONTROL_RESET;
            st.inhibit           <= 2'h0;
            st.rdata             <= 8'h00;
        end else begin
            st <= next_st;
        end
    end

    assign rdata = st.rdata;
    assign irq   = st.interrupt_control[ebtsp_pkg::INT_OVF_BIT]
                 && st.interrupt_control[ebtsp_pkg::INT_OVIE_BIT]
                 && st.interrupt_control[ebtsp_pkg::INT_GIE_BIT];

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    wrap_sets_flag_a: assert property (
        (st.count_value == 8'hFF && inc && !wr_count)
        |=> st.count_value == 8'h00 && st.interrupt_control[ebtsp_pkg::INT_OVF_BIT])
        else $error("wrap did not set overflow flag");

    timer_every_cycle_a: assert property (
        (!src_counter && !to_timer && st.inhibit == 2'h0 && !wr_count && !wr_option)
        |=> st.count_value == $past(st.count_value) + 8'h01)
        else $error("timer mode did not advance every cycle");

    write_inhibit_a: assert property (
        (wr_count ##1 (!wr_count)[*2]) |=> st.count_value == $past(st.count_value, 2))
        else $error("counter advanced inside write inhibit window");

    write_loads_a: assert property (wr_count |=> st.count_value == $past(wdata))
        else $error("counter write not loaded");

    pin_edge_only_a: assert property (
        (src_counter && !to_timer && !wr_count && !wr_option && !pin_rise && !pin_fall)
        |=> $stable(st.count_value))
        else $error("counter mode advanced without a pin edge");

    edge_choice_a: assert property (
        (src_counter && !to_timer && !wr_option && st.inhibit == 2'h0 && !wr_count
         && (edge_falling ? pin_rise : pin_fall))
        |=> $stable(st.count_value))
        else $error("counter advanced on the unselected edge");

    sync_settle_a: assert property (
        pin_rise |-> $past(external_count_input, 2) && $past(external_count_input, 3))
        else $error("pin edge accepted before synchroniser agreed");

    presc_write_clear_a: assert property (
        (wr_count && to_timer && !wr_option) |=> pif.count == 8'h00)
        else $error("counter write did not clear prescaler");

    presc_wdt_clear_a: assert property (
        (watchdog_clear_instr && !to_timer && !wr_option) |=> pif.count == 8'h00)
        else $error("watchdog clear did not clear prescaler");

    wdt_bypass_a: assert property (
        to_timer |-> watchdog_tick_out == watchdog_tick_in)
        else $error("watchdog tick divided while prescaler serves the timer");

    flag_clear_cause_a: assert property (
        $fell(st.interrupt_control[ebtsp_pkg::INT_OVF_BIT]) |-> $past(rd_interrupt_control || wr_interrupt_control))
        else $error("overflow flag cleared without software access");

    sync_rise_level_a: assert property (
        pin_rise |=> pin_level)
        else $error("synchronised level missed a rising edge");

    sync_fall_level_a: assert property (
        pin_fall |=> !pin_level)
        else $error("synchronised level missed a falling edge");

    edge_exclusive_a: assert property (
        !(pin_rise && pin_fall))
        else $error("rising and falling edge seen together");

    inhibit_hold_a: assert property (
        (st.inhibit != 2'h0 && !wr_count) |=> $stable(st.count_value))
        else $error("counter advanced while inhibited");

    option_load_a: assert property (
        wr_option |=> st.option_config == $past(wdata))
        else $error("option write not loaded");

    flag_sticky_a: assert property (
        (st.interrupt_control[ebtsp_pkg::INT_OVF_BIT] && !rd_interrupt_control && !wr_interrupt_control)
        |=> st.interrupt_control[ebtsp_pkg::INT_OVF_BIT])
        else $error("overflow flag dropped without software access");

    read_clears_flag_a: assert property (
        (rd_interrupt_control && !wr_interrupt_control && !overflow)
        |=> !st.interrupt_control[ebtsp_pkg::INT_OVF_BIT])
        else $error("interrupt control read did not clear the flag");

    interrupt_control_unused_a: assert property (
        (st.interrupt_control & ~ebtsp_pkg::INT_IMPL_MASK) == 8'h00)
        else $error("unimplemented interrupt control bit set");

    rdata_idle_a: assert property (
        !rd_en |=> rdata == 8'h00)
        else $error("read data stood beyond one cycle");

    count_read_a: assert property (
        (rd_en && addr_hit(addr, ebtsp_pkg::IDX_COUNT))
        |=> rdata == $past(st.count_value))
        else $error("counter read returned a wrong value");

    presc_gates_count_a: assert property (
        (to_timer && !pif.out_tick && !wr_count)
        |=> $stable(st.count_value))
        else $error("counter advanced without a prescaler tick");

    presc_tick_counts_a: assert property (
        (to_timer && pif.out_tick && st.inhibit == 2'h0 && !wr_count)
        |=> st.count_value == $past(st.count_value) + 8'h01)
        else $error("prescaler tick did not advance the counter");

    wdt_divided_a: assert property (
        (!to_timer && watchdog_tick_out) |-> watchdog_tick_in)
        else $error("divided watchdog tick without a base tick");

    flag_set_cause_a: assert property (
        $rose(st.interrupt_control[ebtsp_pkg::INT_OVF_BIT])
        |-> ($past(st.count_value) == ebtsp_pkg::COUNT_MAX || $past(wr_interrupt_control)))
        else $error("overflow flag set without a wrap");

    pin_counts_a: assert property (
        (src_counter && !to_timer && st.inhibit == 2'h0 && !wr_count
         && (edge_falling ? pin_fall : pin_rise))
        |=> st.count_value == $past(st.count_value) + 8'h01)
        else $error("selected pin edge did not advance the counter");

    interrupt_control_write_a: assert property (
        (wr_interrupt_control && !rd_en && !overflow)
        |=> st.interrupt_control == ($past(wdata) & ebtsp_pkg::INT_IMPL_MASK))
        else $error("interrupt control write not loaded");

    irq_cover:        cover property (overflow ##1 irq);
    pin_count_cover:  cover property (src_counter && inc && edge_falling);
    inhibit_cover:    cover property (wr_count ##1 count_tick ##1 count_tick ##1 inc);
    wdt_clear_cover:  cover property (watchdog_clear_instr && !to_timer);
endmodule

// ==== verification/ebtsp_pulse_src.sv ====
// Model of the pulse source that drives the external count pin.
// Assumes callers time requests to clk_sys; the pin is driven at all times.
`timescale 1ns/100ps
module ebtsp_pulse_src (
    // Clock.
    input  wire logic clk_sys,
    // Pin.
    output logic      pin
);
    // Shortest level the pin synchroniser is sure to catch, in clock cycles.
    localparam int MIN_HOLD = 3;

    initial begin
        pin = 1'b0;
    end

    // Drives a level at a clock edge and holds it; short holds are stretched.
    task automatic set_level(input logic v, input int hold);
        int h;
        h = (hold < MIN_HOLD) ? MIN_HOLD : hold;
        @(posedge clk_sys);
        pin <= v;
        repeat (h) @(posedge clk_sys);
    endtask

    task automatic pulses(input int n, input int half);
        repeat (n) begin
            set_level(1'b1, half);
            set_level(1'b0, half);
        end
    endtask
endmodule

// ==== verification/tb_top.sv ====
// Self-checking bench for the 8-bit timer with shared prescaler.
// Assumes one clk_sys cycle per instruction cycle and the pulse source model on the pin.
`timescale 1ns/100ps
module tb_top;
    localparam logic [ebtsp_pkg::ADDR_W-1:0] A_CNT  = 10'h004;
    localparam logic [ebtsp_pkg::ADDR_W-1:0] A_INT  = 10'h02C;
    localparam logic [ebtsp_pkg::ADDR_W-1:0] A_INTM = 10'h22C;
    localparam logic [ebtsp_pkg::ADDR_W-1:0] A_OPT  = 10'h204;
    localparam logic [ebtsp_pkg::ADDR_W-1:0] A_BAD  = 10'h008;

    logic                          clk_sys;
    logic                          resetn;
    logic [ebtsp_pkg::ADDR_W-1:0]  addr;
    logic [7:0]                    wdata;
    logic                          wr_en;
    logic                          rd_en;
    logic [7:0]                    rdata;
    logic                          external_count_input;
    logic                          watchdog_clear_instr;
    logic                          watchdog_tick_in;
    logic                          watchdog_tick_out;
    logic                          irq;
    int                            fails;
    int                            samples_checked;
    logic [7:0]                    v;
    logic [7:0]                    prev;
    logic [7:0]                    exp5 [5] = '{8'h10, 8'h10, 8'h10, 8'h11, 8'h12};
    int                            n, j, c, i1, i2, p;

    ebtsp_timer dut (
        .clk_sys              (clk_sys),
        .resetn               (resetn),
        .addr                 (addr),
        .wdata                (wdata),
        .wr_en                (wr_en),
        .rd_en                (rd_en),
        .rdata                (rdata),
        .external_count_input (external_count_input),
        .watchdog_clear_instr (watchdog_clear_instr),
        .watchdog_tick_in     (watchdog_tick_in),
        .watchdog_tick_out    (watchdog_tick_out),
        .irq                  (irq)
    );

    ebtsp_pulse_src src (
        .clk_sys (clk_sys),
        .pin     (external_count_input)
    );

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] expv, input string what);
        samples_checked++;
        if (seen !== expv) begin
            fails++;
            $display("ERROR %0t %s: seen %h expected %h", $time, what, seen, expv);
        end
    endtask

    task automatic end_sim();
        if (fails == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Every task starts and ends just after a clock edge, so strobes never toggle twice at once.
    task automatic wr(input logic [ebtsp_pkg::ADDR_W-1:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk_sys);
        wr_en <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [ebtsp_pkg::ADDR_W-1:0] a, output logic [7:0] d);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic idle(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask

    // Feeds k watchdog base ticks and counts the ticks passed on.
    task automatic wd_count(input int k, output int cnt);
        cnt = 0;
        watchdog_tick_in <= 1'b1;
        repeat (k) begin
            @(negedge clk_sys);
            if (watchdog_tick_out === 1'b1) cnt++;
            @(posedge clk_sys);
        end
        watchdog_tick_in <= 1'b0;
        #1;
    endtask

    initial begin
        fails = 0;
        samples_checked = 0;
        resetn = 1'b0;
        addr = '0;
        wdata = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        watchdog_clear_instr = 1'b0;
        watchdog_tick_in = 1'b0;
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        idle(1);
        // Reset values and an unmapped address.
        rd(A_OPT, v); check(v, ebtsp_pkg::OPTION_RESET, "option reset");
        rd(A_INT, v); check(v, 8'h00, "intctl reset");
        rd(A_CNT, v); check(v, 8'h00, "count reset");
        wr(A_BAD, 8'h5A);
        rd(A_BAD, v); check(v, 8'h00, "unmapped read");
        rd(A_OPT, v); check(v, 8'hFF, "option after bad write");
        // Undivided timer mode and the two-cycle hold after a count write.
        wr(A_OPT, 8'h08);
        wr(A_CNT, 8'h10);
        for (j = 0; j < 5; j++) begin
            rd(A_CNT, v); check(v, exp5[j], "write inhibit");
        end
        // Overflow sets the flag and raises the interrupt when both enables are set.
        wr(A_INT, 8'hA0);
        wr(A_CNT, 8'hFD);
        idle(3); check({7'h00, irq}, 8'h00, "irq early");
        idle(2); check({7'h00, irq}, 8'h01, "irq on wrap");
        rd(A_INT, v); check(v, 8'hA4, "flag set");
        rd(A_INT, v); check(v, 8'hA0, "flag cleared");
        check({7'h00, irq}, 8'h00, "irq cleared");
        wr(A_INTM, 8'h24); check({7'h00, irq}, 8'h00, "global off");
        wr(A_INT, 8'hFF); check({7'h00, irq}, 8'h01, "both on");
        rd(A_INTM, v); check(v, 8'hA4, "mirror read");
        wr(A_INT, 8'h84); check({7'h00, irq}, 8'h00, "local off");
        wr(A_INT, 8'h00);
        // Timer-side ratios; a count write restarts the prescaler.
        for (n = 0; n < 8; n++) begin
            wr(A_OPT, 8'(n));
            idle(100);
            wr(A_CNT, 8'h00);
            p = 2 ** (n + 1);
            prev = 8'h00;
            i1 = 0;
            i2 = 0;
            for (j = 1; j <= 3 * p + 10 && i2 == 0; j++) begin
                rd(A_CNT, v);
                if (v !== prev) begin
                    if (i1 == 0) i1 = j;
                    else i2 = j;
                end
                prev = v;
            end
            check(8'(i2 - i1 == p), 8'h01, "timer ratio");
            check(8'(i1 >= p - 2 && i1 <= p + 3), 8'h01, "prescaler restart");
        end
        // Watchdog side: undivided when the timer owns the prescaler, else 2^n.
        wd_count(128, c); check(8'(c), 8'h80, "wd undivided");
        for (n = 0; n < 8; n++) begin
            wr(A_OPT, 8'h08 | 8'(n));
            wd_count(128, c); check(8'(c), 8'(128 >> n), "wd ratio");
        end
        wr(A_OPT, 8'h0B);
        wd_count(3, c);
        watchdog_clear_instr <= 1'b1;
        idle(1);
        watchdog_clear_instr <= 1'b0;
        watchdog_tick_in <= 1'b1;
        c = 0;
        for (j = 1; j <= 20 && c == 0; j++) begin
            @(negedge clk_sys);
            if (watchdog_tick_out === 1'b1) c = j;
            @(posedge clk_sys);
        end
        watchdog_tick_in <= 1'b0;
        #1;
        check(8'(c inside {7, 8}), 8'h01, "wd clear");
        // Counter mode on rising, then falling edges of the pin.
        wr(A_OPT, 8'h28);
        wr(A_CNT, 8'h00);
        idle(4);
        fork
            src.set_level(1'b1, 8);
            begin
                idle(2);
                rd(A_CNT, v); check(v, 8'h00, "sync delay");
            end
        join
        rd(A_CNT, v); check(v, 8'h01, "rising counted");
        src.set_level(1'b0, 8);
        rd(A_CNT, v); check(v, 8'h01, "falling ignored");
        wr(A_OPT, 8'h38);
        wr(A_CNT, 8'h00);
        idle(4);
        src.set_level(1'b1, 8);
        rd(A_CNT, v); check(v, 8'h00, "rising ignored");
        src.set_level(1'b0, 8);
        rd(A_CNT, v); check(v, 8'h01, "falling counted");
        src.pulses(5, 4);
        idle(8);
        rd(A_CNT, v); check(v, 8'h06, "pulse train");
        end_sim();
    end
endmodule
